// File: hdl/lcdcs_pkg.sv
// Constants for the display driver configuration and command state.
// Assumes command bytes arrive already framed by the host interface.
package lcdcs_pkg;
  // ==========================================================
  // Command codes and masks
  localparam logic [7:0] OP_OTP_OFF   = 8'h1c;
  localparam logic [7:0] OP_CALIB     = 8'h1e;
  localparam logic [7:0] OP_SW_RESET  = 8'h71;
  localparam logic [7:0] OP_RNG       = 8'h10;
  localparam logic [7:0] OP_HV        = 8'h12;
  localparam logic [7:0] OP_DCFG      = 8'h17;
  localparam logic [7:0] OP_MIRROR    = 8'h18;
  localparam logic [7:0] OP_FUNC      = 8'h20;
  localparam logic [7:0] OP_DISP      = 8'h08;
  localparam logic [7:0] OP_YADDR     = 8'h40;
  localparam logic [7:0] OP_RLIM      = 8'h50;
  localparam logic [7:0] OP_CLIM      = 8'h60;
  localparam logic [7:0] OP_DLEN      = 8'h70;
  localparam logic [7:0] OP_TCO       = 8'h04;
  localparam logic [7:0] OP_STAGES    = 8'h08;
  localparam logic [7:0] OP_BIAS      = 8'h10;
  localparam logic [7:0] OP_ROW       = 8'h48;
  localparam logic [7:0] OP_NP        = 8'h50;
  localparam logic [7:0] OP_LINE      = 8'h58;
  localparam logic [7:0] OP_RSVD      = 8'h60;
  localparam logic [7:0] OP_MUX       = 8'h68;
  // ==========================================================
  // Reset values
  localparam logic       RST_SLP      = 1'b1;
  localparam logic       RST_HVP      = 1'b1;
  localparam logic       RST_NP       = 1'b1;
  localparam logic [3:0] RST_RLIM     = 4'h8;
  localparam logic [6:0] RST_CLIM     = 7'h65;
  localparam logic [7:0] RST_MASK     = 8'hff;
  // ==========================================================
  // Status byte layout and timing
  localparam int         ST_BUSY      = 7;
  localparam int         ST_DON       = 6;
  localparam int         ST_RIP       = 5;
  localparam int         ST_MK_LO     = 2;
  localparam logic [2:0] SW_RESET_CYCLES = 3'h4;

  typedef enum logic [3:0] {
    LCDCS_P_NONE = 4'h0,
    LCDCS_P_RLIM = 4'h1,
    LCDCS_P_CLIM = 4'h2,
    LCDCS_P_DLEN = 4'h3,
    LCDCS_P_DCFG = 4'h4,
    LCDCS_P_NP   = 4'h5,
    LCDCS_P_MUX  = 4'h6,
    LCDCS_P_ROW  = 4'h7,
    LCDCS_P_LINE = 4'h8,
    LCDCS_P_RSVD = 4'h9
  } lcdcs_pend_e;
endpackage

// File: hdl/lcdcs_top.sv
// Configuration state and command interpreter of a matrix display driver.
// Assumes cmd_wr is a one-cycle write strobe synchronous to clk_sys.
//
// Contract
// - 0x1c disables OTP, 0x1e enters calibration
// - 0x71 software-resets configuration state
// - MSB-set byte loads voltage program value in the extended set, X address in the basic set
// - Power-down bit, reset value one
// - Command-set select bit, reset zero
// - Addressing direction bit, reset horizontal
// - Horizontal and vertical mirror bits reset zero
// - Top and bottom row swap bits
// - Voltage range select bit, reset zero
// - Row driving mode, reset normal
// - HV power control, reset one
// - Start row and line fields, reset zero
// - Max row bank 1000, max column 1100101
// - Two display control bits, reset blank
// - Temperature coefficient field resets 00
// - Multiplication factor field resets 00
// - Partial row mask resets all ones
// - Status byte: busy, on, reset, ids
// - External reset clears all internal registers
// - Reset clears address counters, grounds outputs
// - Power-down stops generators, memory writes kept
`timescale 1ns/1ns
`default_nettype none
module lcdcs_top #(
  parameter logic [2:0] MAKER_ID  = 3'h5, // Arbitrary value
  parameter logic [1:0] DEVICE_ID = 2'h1  // Arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       cmd_wr,
  input  wire logic       dc_sel,
  input  wire logic [7:0] wr_byte,
  output logic            power_down_bit,
  output logic            ext_cmd_set,
  output logic            vert_addr,
  output logic            horizontal_mirror,
  output logic            vertical_mirror,
  output logic            top_row_swap,
  output logic            bottom_row_swap,
  output logic            voltage_range_select,
  output logic            normal_drive,
  output logic            hv_power_control,
  output logic [6:0]      start_row,
  output logic [6:0]      start_line,
  output logic [3:0]      max_row_bank,
  output logic [6:0]      max_column,
  output logic [1:0]      disp_mode,
  output logic [1:0]      temp_coefficient,
  output logic [1:0]      mult_factor,
  output logic [2:0]      bias_sel,
  output logic [7:0]      row_mask,
  output logic [6:0]      voltage_program_value,
  output logic            otp_disabled,
  output logic            calib_mode,
  output logic [7:0]      status_byte,
  output logic            mem_we,
  output logic [6:0]      mem_x,
  output logic [3:0]      mem_y,
  output logic [7:0]      mem_data,
  output logic            outputs_ground,
  output logic            osc_run,
  output logic            hv_gen_on,
  output logic            bias_on
);
  // ==========================================================
  // Reset release
  logic       rst_meta_q;
  logic       rst_n_s;
  logic [2:0] rst_cnt_q;
  logic       busy;
  logic       accept;
  logic       cmd_take;
  logic       sec_take;
  logic [6:0] x_q;
  logic [3:0] y_q;
  lcdcs_pkg::lcdcs_pend_e pend_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_s    <= rst_meta_q;
    end
  end

  // Commands are dropped while a reset runs; the host polls busy
  assign busy     = rst_cnt_q != 3'h0;
  assign accept   = cmd_wr && !busy;
  assign cmd_take = accept && !dc_sel && pend_q == lcdcs_pkg::LCDCS_P_NONE;
  assign sec_take = accept && !dc_sel && pend_q != lcdcs_pkg::LCDCS_P_NONE;

  function automatic logic [6:0] wrap_inc(input logic [6:0] v,
                                          input logic [6:0] lim);
    wrap_inc = (v >= lim) ? 7'h00 : 7'(v + 7'h01);
  endfunction

  // ==========================================================
  // Reset sequencer, shared by pin and command reset
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rst_cnt_q <= lcdcs_pkg::SW_RESET_CYCLES;
    end else if (cmd_take && wr_byte == lcdcs_pkg::OP_SW_RESET) begin
      rst_cnt_q <= lcdcs_pkg::SW_RESET_CYCLES;
    end else if (busy) begin
      rst_cnt_q <= 3'(rst_cnt_q - 3'h1);
    end
  end

  // ==========================================================
  // Double command tracking
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pend_q <= lcdcs_pkg::LCDCS_P_NONE;
    end else if (busy || sec_take) begin
      pend_q <= lcdcs_pkg::LCDCS_P_NONE;
    end else if (cmd_take && wr_byte != lcdcs_pkg::OP_SW_RESET) begin
      if (!ext_cmd_set) begin
        case (wr_byte[7:4])
          4'h5: pend_q <= lcdcs_pkg::LCDCS_P_RLIM;
          4'h6: pend_q <= lcdcs_pkg::LCDCS_P_CLIM;
          4'h7: pend_q <= lcdcs_pkg::LCDCS_P_DLEN;
          default: begin
            if (wr_byte == lcdcs_pkg::OP_DCFG) begin
              pend_q <= lcdcs_pkg::LCDCS_P_DCFG;
            end
          end
        endcase
      end else begin
        case (wr_byte[7:3])
          lcdcs_pkg::OP_ROW[7:3]:  pend_q <= lcdcs_pkg::LCDCS_P_ROW;
          lcdcs_pkg::OP_NP[7:3]:   pend_q <= lcdcs_pkg::LCDCS_P_NP;
          lcdcs_pkg::OP_LINE[7:3]: pend_q <= lcdcs_pkg::LCDCS_P_LINE;
          lcdcs_pkg::OP_RSVD[7:3]: pend_q <= lcdcs_pkg::LCDCS_P_RSVD;
          lcdcs_pkg::OP_MUX[7:3]:  pend_q <= lcdcs_pkg::LCDCS_P_MUX;
          default:                 pend_q <= lcdcs_pkg::LCDCS_P_NONE;
        endcase
      end
    end
  end

  // ==========================================================
  // Configuration bits, held at reset values for the whole reset sequence
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      power_down_bit        <= lcdcs_pkg::RST_SLP;
      ext_cmd_set           <= 1'b0;
      vert_addr             <= 1'b0;
      horizontal_mirror     <= 1'b0;
      vertical_mirror       <= 1'b0;
      top_row_swap          <= 1'b0;
      bottom_row_swap       <= 1'b0;
      voltage_range_select  <= 1'b0;
      normal_drive          <= lcdcs_pkg::RST_NP;
      hv_power_control      <= lcdcs_pkg::RST_HVP;
      start_row             <= 7'h00;
      start_line            <= 7'h00;
      max_row_bank          <= lcdcs_pkg::RST_RLIM;
      max_column            <= lcdcs_pkg::RST_CLIM;
      disp_mode             <= 2'h0;
      temp_coefficient      <= 2'h0;
      mult_factor           <= 2'h0;
      bias_sel              <= 3'h0;
      row_mask              <= lcdcs_pkg::RST_MASK;
      voltage_program_value <= 7'h00;
    end else if (busy) begin
      power_down_bit        <= lcdcs_pkg::RST_SLP;
      ext_cmd_set           <= 1'b0;
      vert_addr             <= 1'b0;
      horizontal_mirror     <= 1'b0;
      vertical_mirror       <= 1'b0;
      top_row_swap          <= 1'b0;
      bottom_row_swap       <= 1'b0;
      voltage_range_select  <= 1'b0;
      normal_drive          <= lcdcs_pkg::RST_NP;
      hv_power_control      <= lcdcs_pkg::RST_HVP;
      start_row             <= 7'h00;
      start_line            <= 7'h00;
      max_row_bank          <= lcdcs_pkg::RST_RLIM;
      max_column            <= lcdcs_pkg::RST_CLIM;
      disp_mode             <= 2'h0;
      temp_coefficient      <= 2'h0;
      mult_factor           <= 2'h0;
      bias_sel              <= 3'h0;
      row_mask              <= lcdcs_pkg::RST_MASK;
      voltage_program_value <= 7'h00;
    end else if (sec_take) begin
      case (pend_q)
        lcdcs_pkg::LCDCS_P_RLIM: max_row_bank <= wr_byte[3:0];
        lcdcs_pkg::LCDCS_P_CLIM: max_column   <= wr_byte[6:0];
        lcdcs_pkg::LCDCS_P_DCFG: begin
          top_row_swap    <= wr_byte[1];
          bottom_row_swap <= wr_byte[0];
        end
        lcdcs_pkg::LCDCS_P_NP:   normal_drive <= wr_byte[0];
        lcdcs_pkg::LCDCS_P_MUX:  row_mask     <= wr_byte;
        lcdcs_pkg::LCDCS_P_ROW:  start_row    <= wr_byte[6:0];
        lcdcs_pkg::LCDCS_P_LINE: start_line   <= wr_byte[6:0];
        default: ;
      endcase
    end else if (cmd_take) begin
      if (wr_byte[7:3] == lcdcs_pkg::OP_FUNC[7:3]) begin
        power_down_bit <= wr_byte[2];
        vert_addr      <= wr_byte[1];
        ext_cmd_set    <= wr_byte[0];
      end else if (ext_cmd_set) begin
        if (wr_byte[7]) begin
          voltage_program_value <= wr_byte[6:0];
        end else if (wr_byte[7:2] == lcdcs_pkg::OP_TCO[7:2]) begin
          temp_coefficient <= wr_byte[1:0];
        end else if (wr_byte[7:2] == lcdcs_pkg::OP_STAGES[7:2]) begin
          mult_factor <= wr_byte[1:0];
        end else if (wr_byte[7:3] == lcdcs_pkg::OP_BIAS[7:3]) begin
          bias_sel <= wr_byte[2:0];
        end
      end else begin
        if (wr_byte[7:1] == lcdcs_pkg::OP_RNG[7:1]) begin
          voltage_range_select <= wr_byte[0];
        end else if (wr_byte[7:1] == lcdcs_pkg::OP_HV[7:1]) begin
          hv_power_control <= wr_byte[0];
        end else if (wr_byte[7:2] == lcdcs_pkg::OP_MIRROR[7:2]) begin
          horizontal_mirror <= wr_byte[1];
          vertical_mirror   <= wr_byte[0];
        end else if (wr_byte[7:3] == lcdcs_pkg::OP_DISP[7:3] &&
                     !wr_byte[1]) begin
          disp_mode <= {wr_byte[2], wr_byte[0]};
        end
      end
    end
  end

  // ==========================================================
  // One-time programming control; only a pin reset clears it
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      otp_disabled <= 1'b0;
      calib_mode   <= 1'b0;
    end else if (cmd_take && wr_byte == lcdcs_pkg::OP_OTP_OFF) begin
      otp_disabled <= 1'b1;
    end else if (cmd_take && wr_byte == lcdcs_pkg::OP_CALIB) begin
      calib_mode   <= 1'b1;
    end
  end

  // ==========================================================
  // Address counters and memory write port, live in power-down
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      x_q <= 7'h00;
      y_q <= 4'h0;
    end else if (busy) begin
      x_q <= 7'h00;
      y_q <= 4'h0;
    end else if (accept && dc_sel) begin
      if (!vert_addr) begin
        x_q <= wrap_inc(x_q, max_column);
        if (x_q >= max_column) begin
          y_q <= 4'(wrap_inc({3'h0, y_q}, {3'h0, max_row_bank}));
        end
      end else begin
        y_q <= 4'(wrap_inc({3'h0, y_q}, {3'h0, max_row_bank}));
        if (y_q >= max_row_bank) begin
          x_q <= wrap_inc(x_q, max_column);
        end
      end
    end else if (cmd_take && !ext_cmd_set) begin
      if (wr_byte[7]) begin
        x_q <= wr_byte[6:0];
      end else if (wr_byte[7:4] == lcdcs_pkg::OP_YADDR[7:4]) begin
        y_q <= wr_byte[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      mem_we   <= 1'b0;
      mem_x    <= 7'h00;
      mem_y    <= 4'h0;
      mem_data <= 8'h00;
    end else begin
      mem_we   <= accept && dc_sel;
      mem_x    <= horizontal_mirror ? 7'(max_column - x_q) : x_q;
      mem_y    <= y_q;
      mem_data <= wr_byte;
    end
  end

  // ==========================================================
  // Analog enables and status byte
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      outputs_ground <= 1'b1;
      osc_run        <= 1'b0;
      hv_gen_on      <= 1'b0;
      bias_on        <= 1'b0;
    end else begin
      outputs_ground <= power_down_bit || disp_mode == 2'h0;
      osc_run        <= !power_down_bit;
      bias_on        <= !power_down_bit;
      // A zero program value leaves the generator programmed off
      hv_gen_on      <= !power_down_bit && hv_power_control &&
                        voltage_program_value != 7'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      status_byte <= 8'h00;
    end else begin
      status_byte[lcdcs_pkg::ST_BUSY] <= busy;
      status_byte[lcdcs_pkg::ST_DON]  <= !power_down_bit &&
                                         disp_mode != 2'h0;
      status_byte[lcdcs_pkg::ST_RIP]  <= busy;
      status_byte[lcdcs_pkg::ST_MK_LO +: 3] <= MAKER_ID;
      status_byte[1:0] <= DEVICE_ID;
    end
  end

  // ==========================================================
  // Checks
  AST_OTP_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    cmd_take && wr_byte == 8'h1c |=> otp_disabled)
    else $error("otp disable command not taken");

  AST_SWRST: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    cmd_take && wr_byte == 8'h71 |-> ##2 (status_byte[5] &&
      status_byte[7] && power_down_bit && row_mask == 8'hff))
    else $error("software reset did not restore state");

  AST_RES_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    $rose(busy) |-> busy [*4] ##1 !busy)
    else $error("reset sequence length wrong");

  AST_VPR_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    cmd_take && ext_cmd_set && wr_byte[7] && wr_byte != 8'h71
    |=> voltage_program_value == $past(wr_byte[6:0]))
    else $error("voltage program value not loaded");

  AST_DCTRL: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    cmd_take && !ext_cmd_set && wr_byte[7:3] == 5'h01 && !wr_byte[1]
    |=> disp_mode == {$past(wr_byte[2]), $past(wr_byte[0])})
    else $error("display control bits wrong");

  AST_PC_SET: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    cmd_take && !ext_cmd_set && wr_byte[7:1] == 7'h09
    |=> hv_power_control == $past(wr_byte[0]))
    else $error("power control bit wrong");

  AST_MASK: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    sec_take && pend_q == lcdcs_pkg::LCDCS_P_MUX
    |=> row_mask == $past(wr_byte))
    else $error("row mask not loaded");

  AST_HINC: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    accept && dc_sel && !vert_addr && x_q < max_column
    |=> x_q == 7'($past(x_q) + 7'h01))
    else $error("horizontal address did not advance");

  AST_PD_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    power_down_bit |=> outputs_ground && !osc_run && !hv_gen_on
      && !bias_on && !status_byte[6])
    else $error("power-down left generators running");

  AST_PD_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
    accept && dc_sel |=> mem_we && mem_data == $past(wr_byte))
    else $error("memory write lost");
endmodule
`default_nettype wire

// File: testbench/lcdcs_host.sv
// Host controller model driving the command and data write port.
// Assumes the bench calls its tasks; everything moves on rising edges.
`timescale 1ns/1ns
`default_nettype none
module lcdcs_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] status_byte,
  output var  logic       resetn,
  output var  logic       cmd_wr,
  output var  logic       dc_sel,
  output var  logic [7:0] wr_byte
);
  initial begin
    resetn  = 1'b0;
    cmd_wr  = 1'b0;
    dc_sel  = 1'b0;
    wr_byte = 8'h00;
  end
  // ==========================================================
  // Reset pin
  task automatic pulse_reset(input int cycles);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (cycles) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask
  // ==========================================================
  // Byte writes; an impolite write ignores busy on purpose
  task automatic send(input logic dc, input logic [7:0] b, input bit polite);
    int n;
    n = 0;
    while (polite && status_byte[7] !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    cmd_wr  <= 1'b1;
    dc_sel  <= dc;
    wr_byte <= b;
    @(posedge clk_sys);
    cmd_wr  <= 1'b0;
    // Idle bus shows no stale byte
    wr_byte <= ~b;
    #1;
  endtask
endmodule
`default_nettype wire

// File: testbench/lcdcs_top_tb_top.sv
// Self-checking bench for the display driver configuration state.
// Assumes lcdcs_host drives the write port; expected state lives here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module lcdcs_top_tb_top;
  localparam logic [2:0] MID = 3'h3; // Arbitrary value
  localparam logic [1:0] DID = 2'h2; // Arbitrary value
  logic       clk_sys = 1'b0;
  logic       resetn, cmd_wr, dc_sel, power_down_bit, ext_cmd_set;
  logic       vert_addr, horizontal_mirror, vertical_mirror, top_row_swap;
  logic       bottom_row_swap, voltage_range_select, normal_drive;
  logic       hv_power_control, otp_disabled, calib_mode, mem_we;
  logic       outputs_ground, osc_run, hv_gen_on, bias_on;
  logic [6:0] start_row, start_line, max_column, voltage_program_value;
  logic [6:0] mem_x, e_row, e_line, e_clim, e_volt;
  logic [3:0] max_row_bank, mem_y, e_rlim;
  logic [1:0] disp_mode, temp_coefficient, mult_factor, e_dm, e_tco, e_s;
  logic [2:0] bias_sel, e_bs;
  logic [7:0] row_mask, mem_data, status_byte, wr_byte, e_mask;
  logic       e_slp, e_h, e_v, e_hmir, e_vmir, e_tsw, e_bsw, e_rng, e_np;
  logic       e_hvp;
  int         ex, ey;
  int         num_errors = 0;
  int         total_checks = 0;

  initial forever #20 clk_sys = ~clk_sys;

  lcdcs_host i_host (.clk_sys, .status_byte, .resetn, .cmd_wr, .dc_sel,
    .wr_byte);
  lcdcs_top #(.MAKER_ID(MID), .DEVICE_ID(DID)) i_dut (.clk_sys, .resetn,
    .cmd_wr, .dc_sel, .wr_byte, .power_down_bit, .ext_cmd_set, .vert_addr,
    .horizontal_mirror, .vertical_mirror, .top_row_swap, .bottom_row_swap,
    .voltage_range_select, .normal_drive, .hv_power_control, .start_row,
    .start_line, .max_row_bank, .max_column, .disp_mode, .temp_coefficient,
    .mult_factor, .bias_sel, .row_mask, .voltage_program_value,
    .otp_disabled, .calib_mode, .status_byte, .mem_we, .mem_x, .mem_y,
    .mem_data, .outputs_ground, .osc_run, .hv_gen_on, .bias_on);

  // ==========================================================
  // Reference model
  task automatic model_reset;
    {e_slp, e_hvp, e_np} = 3'h7;
    {e_h, e_v, e_hmir, e_vmir, e_tsw, e_bsw, e_rng} = 7'h00;
    {e_row, e_line, e_volt} = 21'h000000;
    e_rlim = 4'h8;
    e_clim = 7'h65;
    e_mask = 8'hff;
    {e_dm, e_tco, e_s, e_bs} = 9'h000;
    ex = 0;
    ey = 0;
  endtask
  task automatic check_all;
    `CHK(power_down_bit, e_slp)
    `CHK(ext_cmd_set, e_h)
    `CHK(vert_addr, e_v)
    `CHK({horizontal_mirror, vertical_mirror}, {e_hmir, e_vmir})
    `CHK({top_row_swap, bottom_row_swap}, {e_tsw, e_bsw})
    `CHK(voltage_range_select, e_rng)
    `CHK(normal_drive, e_np)
    `CHK(hv_power_control, e_hvp)
    `CHK({start_row, start_line}, {e_row, e_line})
    `CHK({max_row_bank, max_column}, {e_rlim, e_clim})
    `CHK(disp_mode, e_dm)
    `CHK(temp_coefficient, e_tco)
    `CHK(mult_factor, e_s)
    `CHK(row_mask, e_mask)
    `CHK(voltage_program_value, e_volt)
    `CHK(bias_sel, e_bs)
  endtask
  // ==========================================================
  // Stimulus helpers
  task automatic cmd(input logic [7:0] b);
    i_host.send(1'b0, b, 1'b1);
  endtask
  task automatic dbl(input logic [7:0] op, input logic [7:0] arg);
    cmd(op);
    cmd(arg);
  endtask
  task automatic put_data(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($urandom);
      i_host.send(1'b1, b, 1'b1);
      `CHK({mem_we, mem_data}, {1'b1, b})
      `CHK({mem_x, mem_y}, {7'(ex), 4'(ey)})
      ex++;
      if (ex > int'(e_clim)) begin
        ex = 0;
        ey++;
      end
    end
  endtask
  task automatic wait_flag(input logic lvl);
    int n;
    n = 0;
    while (status_byte[7] !== lvl && n < 12) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic wait_reset_done;
    wait_flag(1'b1);
    `CHK({status_byte[7], status_byte[5]}, 2'b11)
    wait_flag(1'b0);
    `CHK({status_byte[7], status_byte[5:0]}, {2'b00, MID, DID})
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    int         i;
    logic [7:0] r;
    void'($urandom(32'h54a1174f));
    model_reset();
    i_host.pulse_reset(5);
    wait_reset_done();
    check_all();
    `CHK({outputs_ground, osc_run, hv_gen_on, bias_on}, 4'h8)
    put_data(1);
    // Tiny column limit so the wrap shows after two writes
    dbl(8'h60, 8'h03);
    e_clim = 7'h03;
    cmd(8'h82);
    ex = 2;
    put_data(3);
    for (i = 0; i < 8; i++) begin
      cmd(8'h20 | 8'(i));
      {e_slp, e_v, e_h} = 3'(i);
      check_all();
    end
    cmd(8'h21);
    {e_slp, e_v, e_h} = 3'h1;
    @(posedge clk_sys);
    #1;
    `CHK(osc_run, 1'b1)
    for (i = 0; i < 4; i++) begin
      cmd(8'h04 | 8'(i));
      e_tco = 2'(i);
      cmd(8'h08 | 8'(i));
      e_s = 2'(i);
      check_all();
    end
    r = 8'($urandom);
    cmd(8'h10 | {5'h00, r[2:0]});
    e_bs = r[2:0];
    dbl(8'h68, r);
    e_mask = r;
    r = 8'($urandom_range(66));
    dbl(8'h48, r);
    e_row = r[6:0];
    r = 8'($urandom_range(66));
    dbl(8'h58, r);
    e_line = r[6:0];
    dbl(8'h50, 8'h00);
    e_np = 1'b0;
    cmd(8'hff);
    e_volt = 7'h7f;
    check_all();
    // Enables follow their cause registers one edge later
    @(posedge clk_sys);
    #1;
    `CHK({outputs_ground, osc_run, hv_gen_on, bias_on}, 4'hf)
    `CHK(status_byte[6], 1'b0)
    cmd(8'h20);
    e_h = 1'b0;
    for (i = 0; i < 4; i++) begin
      cmd(8'h10 | 8'(i[0]));
      e_rng = i[0];
      cmd(8'h12 | 8'(i[1]));
      e_hvp = i[1];
      dbl(8'h17, 8'(i));
      {e_tsw, e_bsw} = 2'(i);
      cmd(8'h18 | 8'(i));
      {e_hmir, e_vmir} = 2'(i);
      cmd(8'h08 | 8'({i[1], 1'b0, i[0]}));
      e_dm = 2'(i);
      check_all();
    end
    r = 8'($urandom_range(8));
    dbl(8'h50, r);
    e_rlim = r[3:0];
    r = 8'($urandom_range(101));
    dbl(8'h60, r);
    e_clim = r[6:0];
    check_all();
    cmd(8'h1c);
    `CHK({otp_disabled, calib_mode}, 2'b10)
    cmd(8'h1e);
    `CHK({otp_disabled, calib_mode}, 2'b11)
    cmd(8'h71);
    wait_flag(1'b1);
    // Written while busy, so it must leave no trace
    i_host.send(1'b0, 8'h21, 1'b0);
    wait_flag(1'b0);
    model_reset();
    check_all();
    `CHK({otp_disabled, calib_mode}, 2'b11)
    put_data(1);
    cmd(8'h20);
    i_host.pulse_reset(3);
    wait_reset_done();
    // Pin reset also clears the address counters the model tracks
    model_reset();
    check_all();
    `CHK({otp_disabled, calib_mode, outputs_ground}, 3'b001)
    put_data(1);
    close_out();
  end
endmodule
`default_nettype wire
